// ==== shared/plh_pkg.sv ====
`default_nettype none

package plh_pkg;

  // ----------------------------------------------------------------
  // serial frame layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int RD_BIT = 7;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [3:0] WORD_LAST = 4'hf;

  // ----------------------------------------------------------------
  // pages and common offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_LOW = 8'h07;
  localparam logic [7:0] PAGE_HYST = 8'h08;
  localparam logic [6:0] OFS_NOP = 7'h00;
  localparam logic [6:0] OFS_PAGE = 7'h01;
  localparam logic [6:0] OFS_CONVERT = 7'h02;
  localparam logic [6:0] OFS_RESULT = 7'h03;
  localparam logic [6:0] OFS_DAC_EN = 7'h04;
  localparam logic [6:0] OFS_GPIO = 7'h05;
  localparam logic [6:0] OFS_DEV_ID = 7'h0c;
  localparam logic [6:0] OFS_SOFT_RST = 7'h0f;
  localparam logic [6:0] OFS_PAGED = 7'h10;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // threshold field: msb in bit 15, lsb in bit 4, bits 3..0 reserved
  // ----------------------------------------------------------------
  localparam int THR_W = 12;
  localparam int THR_LSB = 4;
  localparam logic [3:0] RSVD_LOW = 4'h0;
  localparam logic [11:0] RST_THR = 12'h000;

  // ----------------------------------------------------------------
  // paged register maps
  // ----------------------------------------------------------------
  localparam int LOW_N = 12;
  localparam int HYST_N = 11;
  localparam logic [6:0] LOW_OFS [0:LOW_N-1] = '{
    7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17,
    7'h28, 7'h29, 7'h2a, 7'h2b};
  localparam logic [6:0] HYST_OFS [0:HYST_N-1] = '{
    7'h10, 7'h11, 7'h12, 7'h13, 7'h20, 7'h21, 7'h22,
    7'h28, 7'h29, 7'h2a, 7'h2b};

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_LOAD,
    ST_DATA
  } plh_state_t;

endpackage

`default_nettype wire

// ==== src/plh_bank.sv ====
// Function
// RQ1 - With page 0x07 selected, offsets 0x10 and up reach the low-limit registers, all zero after reset.
// RQ2 - Low-limit offsets 0x10 to 0x13 are 16-bit read/write limits for the four supply channels in order.
// RQ3 - Low-limit offsets 0x14 to 0x17 hold the limits of the four bipolar output monitor channels.
// RQ4 - Low-limit offsets 0x28 to 0x2b hold the limits of the four shunt positive monitors in order.
// RQ5 - Each limit keeps a 12-bit threshold in bits 15 to 4 and bits 3 to 0 are reserved.
// RQ6 - With page 0x08 selected, offsets 0x10-0x13, 0x20-0x22 and 0x28-0x2b are zero-reset hysteresis.
// RQ7 - Offset 0x02 is a write-only trigger with no storage and 0x03 is a read-only zero-reset result; the code keeps the 0x02 byte on convert_code.
// RQ8 - Offsets 0x00 to 0x0f decode the same on every page so the page pointer is always reachable.
// RQ9 - The host writes bit 15 of every temperature hysteresis register as one.
`timescale 1ns/1ps
`default_nettype none

module plh_bank #(
  parameter logic [15:0] DEV_ID = 16'h5a5a  // arbitrary value
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // serial register port
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  // conversion engine
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  output logic convert_strobe,
  output logic [7:0] convert_code,
  // common controls
  output logic [7:0] page_select,
  output logic [7:0] dac_output_enable,
  output logic [7:0] gpio_levels,
  output logic [15:0] soft_reset_control,
  // thresholds for the alert logic
  output logic [plh_pkg::LOW_N*plh_pkg::THR_W-1:0] low_limits,
  output logic [plh_pkg::HYST_N*plh_pkg::THR_W-1:0] hysteresis
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (plh_pkg::THR_W + plh_pkg::THR_LSB != 16) begin : g_bad_field
    $error("threshold field does not fill a 16-bit word");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_m_ff;
  logic [2:0] pin_s_ff;
  logic sclk_d_ff;
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic sclk_rise;
  logic sclk_fall;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_m_ff <= 3'h4;
      pin_s_ff <= 3'h4;
      sclk_d_ff <= 1'b0;
    end else begin
      pin_m_ff <= {cs_n, sclk, sdi};
      pin_s_ff <= pin_m_ff;
      sclk_d_ff <= pin_s_ff[1];
    end
  end

  assign cs_n_s = pin_s_ff[2];
  assign sclk_s = pin_s_ff[1];
  assign sdi_s = pin_s_ff[0];
  // sclk is oversampled, so it must stay below a quarter of core_clk
  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s & sclk_d_ff;

  // ----------------------------------------------------------------
  // frame state machine
  // ----------------------------------------------------------------
  plh_pkg::plh_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [15:0] rx_ff, nxt_rx;
  logic [15:0] tx_ff, nxt_tx;
  logic [6:0] addr_ff, nxt_addr;
  logic rd_ff, nxt_rd;
  logic wr_stb_ff, nxt_wr_stb;
  logic [15:0] wr_data_ff, nxt_wr_data;
  logic [15:0] rx_in;
  logic is16;
  logic [3:0] last_bit;
  logic [15:0] rdata;
  logic [15:0] tx_load;

  assign rx_in = {rx_ff[14:0], sdi_s};
  assign is16 = (addr_ff == plh_pkg::OFS_RESULT) || (addr_ff == plh_pkg::OFS_DEV_ID) ||
                (addr_ff == plh_pkg::OFS_SOFT_RST) || (addr_ff >= plh_pkg::OFS_PAGED);
  assign last_bit = is16 ? plh_pkg::WORD_LAST : plh_pkg::BYTE_LAST;
  // byte registers go out left-justified so the msb is always first
  assign tx_load = is16 ? rdata : {rdata[7:0], plh_pkg::RST_BYTE};

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_addr = addr_ff;
    nxt_rd = rd_ff;
    nxt_wr_stb = 1'b0;
    nxt_wr_data = wr_data_ff;
    case (state_ff)
      plh_pkg::ST_IDLE: begin
        if (!cs_n_s) begin
          nxt_state = plh_pkg::ST_ADDR;
          nxt_cnt = '0;
        end
      end
      plh_pkg::ST_ADDR: begin
        if (cs_n_s) begin
          nxt_state = plh_pkg::ST_IDLE;
        end else if (sclk_rise) begin
          nxt_rx = rx_in;
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == plh_pkg::BYTE_LAST) begin
            nxt_addr = rx_in[plh_pkg::ADDR_W-1:0];
            nxt_rd = rx_in[plh_pkg::RD_BIT];
            nxt_state = plh_pkg::ST_LOAD;
          end
        end
      end
      plh_pkg::ST_LOAD: begin
        nxt_tx = tx_load;
        nxt_cnt = '0;
        nxt_state = cs_n_s ? plh_pkg::ST_IDLE : plh_pkg::ST_DATA;
      end
      plh_pkg::ST_DATA: begin
        if (cs_n_s) begin
          // a frame cut short never writes
          nxt_state = plh_pkg::ST_IDLE;
        end else if (sclk_rise) begin
          nxt_rx = rx_in;
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == last_bit) begin
            nxt_wr_stb = ~rd_ff;
            nxt_wr_data = rx_in;
            nxt_cnt = '0;
            nxt_state = plh_pkg::ST_ADDR;
          end
        end else if (sclk_fall && rd_ff && cnt_ff != 4'h0) begin
          nxt_tx = {tx_ff[14:0], 1'b0};
        end
      end
      default: begin
        nxt_state = plh_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= plh_pkg::ST_IDLE;
      cnt_ff <= '0;
      rx_ff <= plh_pkg::RST_WORD;
      tx_ff <= plh_pkg::RST_WORD;
      addr_ff <= plh_pkg::OFS_NOP;
      rd_ff <= 1'b0;
      wr_stb_ff <= 1'b0;
      wr_data_ff <= plh_pkg::RST_WORD;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      addr_ff <= nxt_addr;
      rd_ff <= nxt_rd;
      wr_stb_ff <= nxt_wr_stb;
      wr_data_ff <= nxt_wr_data;
    end
  end

  assign sdo = tx_ff[15];
  assign sdo_oe_n = ~((state_ff == plh_pkg::ST_DATA) && rd_ff);

  // ----------------------------------------------------------------
  // common registers, same on every page
  // ----------------------------------------------------------------
  logic [7:0] page_ff;
  logic [7:0] dac_en_ff;
  logic [7:0] gpio_ff;
  logic [15:0] soft_rst_ff;
  logic [15:0] result_ff;
  logic convert_ff;
  logic [7:0] convert_code_ff;
  logic wr_page;
  logic wr_convert;

  assign wr_page = wr_stb_ff && addr_ff == plh_pkg::OFS_PAGE;  // RQ8
  assign wr_convert = wr_stb_ff && addr_ff == plh_pkg::OFS_CONVERT;  // RQ7

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      page_ff <= plh_pkg::RST_BYTE;
      dac_en_ff <= plh_pkg::RST_BYTE;
      gpio_ff <= plh_pkg::RST_BYTE;
      soft_rst_ff <= plh_pkg::RST_WORD;
      result_ff <= plh_pkg::RST_WORD;
      convert_ff <= 1'b0;
      convert_code_ff <= plh_pkg::RST_BYTE;
    end else begin
      if (wr_page) page_ff <= wr_data_ff[7:0];  // RQ8
      if (wr_stb_ff && addr_ff == plh_pkg::OFS_DAC_EN) dac_en_ff <= wr_data_ff[7:0];
      if (wr_stb_ff && addr_ff == plh_pkg::OFS_GPIO) gpio_ff <= wr_data_ff[7:0];
      if (wr_stb_ff && addr_ff == plh_pkg::OFS_SOFT_RST) soft_rst_ff <= wr_data_ff;
      // result only follows the engine; bus writes never reach it
      if (result_valid) result_ff <= result_data;  // RQ7
      convert_ff <= wr_convert;  // RQ7
      if (wr_convert) convert_code_ff <= wr_data_ff[7:0];
    end
  end

  assign convert_strobe = convert_ff;
  assign convert_code = convert_code_ff;
  assign page_select = page_ff;
  assign dac_output_enable = dac_en_ff;
  assign gpio_levels = gpio_ff;
  assign soft_reset_control = soft_rst_ff;

  // ----------------------------------------------------------------
  // paged limit and hysteresis registers
  // ----------------------------------------------------------------
  logic page_low;
  logic page_hyst;
  logic [plh_pkg::LOW_N:0] low_any;
  logic [plh_pkg::HYST_N:0] hyst_any;
  logic [plh_pkg::THR_W-1:0] low_rd [0:plh_pkg::LOW_N];
  logic [plh_pkg::THR_W-1:0] hyst_rd [0:plh_pkg::HYST_N];

  assign page_low = page_ff == plh_pkg::PAGE_LOW;  // RQ1
  assign page_hyst = page_ff == plh_pkg::PAGE_HYST;  // RQ6
  assign low_any[0] = 1'b0;
  assign hyst_any[0] = 1'b0;
  assign low_rd[0] = plh_pkg::RST_THR;
  assign hyst_rd[0] = plh_pkg::RST_THR;

  // entries 0-3 supplies, 4-7 bipolar monitors, 8-11 shunt monitors
  for (genvar i = 0; i < plh_pkg::LOW_N; i++) begin : g_low
    logic [plh_pkg::THR_W-1:0] thr_ff;
    logic hit;
    assign hit = page_low && addr_ff == plh_pkg::LOW_OFS[i];  // RQ1
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        thr_ff <= plh_pkg::RST_THR;  // RQ1
      end else if (wr_stb_ff && hit) begin
        thr_ff <= wr_data_ff[15:plh_pkg::THR_LSB];  // RQ2 RQ3 RQ4 RQ5
      end
    end
    assign low_any[i+1] = low_any[i] | hit;
    assign low_rd[i+1] = low_rd[i] | (hit ? thr_ff : plh_pkg::RST_THR);
    assign low_limits[i*plh_pkg::THR_W +: plh_pkg::THR_W] = thr_ff;
  end

  // entries 0-3 voltage inputs, 4-6 temperatures, 7-10 current sense
  for (genvar j = 0; j < plh_pkg::HYST_N; j++) begin : g_hyst
    logic [plh_pkg::THR_W-1:0] thr_ff;
    logic hit;
    assign hit = page_hyst && addr_ff == plh_pkg::HYST_OFS[j];  // RQ6
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        thr_ff <= plh_pkg::RST_THR;  // RQ6
      end else if (wr_stb_ff && hit) begin
        // temperature bit 15 is stored as written, never forced
        thr_ff <= wr_data_ff[15:plh_pkg::THR_LSB];  // RQ6 RQ9
      end
    end
    assign hyst_any[j+1] = hyst_any[j] | hit;
    assign hyst_rd[j+1] = hyst_rd[j] | (hit ? thr_ff : plh_pkg::RST_THR);
    assign hysteresis[j*plh_pkg::THR_W +: plh_pkg::THR_W] = thr_ff;
  end

  // ----------------------------------------------------------------
  // read selection; unmapped offsets and other pages read zero
  // ----------------------------------------------------------------
  logic [15:0] common_rd;
  logic [15:0] paged_rd;

  assign common_rd =
    (addr_ff == plh_pkg::OFS_PAGE) ? {plh_pkg::RST_BYTE, page_ff} :
    (addr_ff == plh_pkg::OFS_RESULT) ? result_ff :
    (addr_ff == plh_pkg::OFS_DAC_EN) ? {plh_pkg::RST_BYTE, dac_en_ff} :
    (addr_ff == plh_pkg::OFS_GPIO) ? {plh_pkg::RST_BYTE, gpio_ff} :
    (addr_ff == plh_pkg::OFS_DEV_ID) ? DEV_ID :
    (addr_ff == plh_pkg::OFS_SOFT_RST) ? soft_rst_ff :
    plh_pkg::RST_WORD;  // RQ7 RQ8
  assign paged_rd =
    low_any[plh_pkg::LOW_N] ? {low_rd[plh_pkg::LOW_N], plh_pkg::RSVD_LOW} :
    hyst_any[plh_pkg::HYST_N] ? {hyst_rd[plh_pkg::HYST_N], plh_pkg::RSVD_LOW} :
    plh_pkg::RST_WORD;  // RQ5
  assign rdata = (addr_ff < plh_pkg::OFS_PAGED) ? common_rd : paged_rd;  // RQ8

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_limits_reset_zero: assert property (  // RQ1
    @(posedge core_clk) $rose(reset_n) |-> (low_limits == '0 && hysteresis == '0))
    else $error("limit or hysteresis not zero after reset");

  a_supply_limit_wr: assert property (  // RQ2
    @(posedge core_clk) disable iff (!reset_n)
    (wr_stb_ff && page_low && addr_ff == 7'h13)
    |=> low_limits[47:36] == $past(wr_data_ff[15:4]))
    else $error("negative supply low limit not written");

  a_monitor_limit_wr: assert property (  // RQ3
    @(posedge core_clk) disable iff (!reset_n)
    (wr_stb_ff && page_low && addr_ff == 7'h14)
    |=> low_limits[59:48] == $past(wr_data_ff[15:4]) && $stable(low_limits[47:0]))
    else $error("bipolar monitor 0 low limit write wrong");

  a_shunt_limit_wr: assert property (  // RQ4
    @(posedge core_clk) disable iff (!reset_n)
    (wr_stb_ff && page_low && addr_ff == 7'h2b)
    |=> low_limits[143:132] == $past(wr_data_ff[15:4]))
    else $error("shunt monitor 3 low limit not written");

  a_reserved_reads_zero: assert property (  // RQ5
    @(posedge core_clk) disable iff (!reset_n)
    (state_ff == plh_pkg::ST_LOAD && addr_ff >= 7'h10)
    |=> (state_ff != plh_pkg::ST_DATA) || tx_ff[3:0] == 4'h0)
    else $error("reserved limit bits read non-zero");

  a_temp_hyst_wr: assert property (  // RQ6
    @(posedge core_clk) disable iff (!reset_n)
    (wr_stb_ff && page_hyst && addr_ff == 7'h22)
    |=> hysteresis[83:72] == $past(wr_data_ff[15:4]) && $stable(low_limits))
    else $error("diode 1 hysteresis write wrong");

  a_convert_one_pulse: assert property (  // RQ7
    @(posedge core_clk) disable iff (!reset_n)
    convert_strobe |-> $past(wr_stb_ff && addr_ff == 7'h02) ##1 !convert_strobe)
    else $error("convert strobe not a single pulse after a write");

  a_result_read_only: assert property (  // RQ7
    @(posedge core_clk) disable iff (!reset_n)
    (wr_stb_ff && addr_ff == 7'h03 && !result_valid) |=> $stable(result_ff))
    else $error("result register changed by a bus write");

  a_page_any_page: assert property (  // RQ8
    @(posedge core_clk) disable iff (!reset_n)
    (wr_stb_ff && addr_ff == 7'h01) |=> page_select == $past(wr_data_ff[7:0]))
    else $error("page pointer write lost");

endmodule  // plh_bank

`default_nettype wire

// ==== test/plh_host.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// serial host model, mode 0, msb first
// ----------------------------------------------------------------
module plh_host (
  // clock
  input wire logic core_clk,
  // serial register port
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // 8 core clocks per half period keeps the synchroniser well ahead
  task automatic bit_xfer(input logic b, output logic got);
    sdi <= b;
    wait_clk(7);
    @(negedge core_clk) got = sdo;
    @(posedge core_clk) sclk <= 1'b1;
    wait_clk(8);
    sclk <= 1'b0;
  endtask

  // address byte then data; width follows the register map
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] wdata,
                      output logic [15:0] rdata);
    int nb;
    logic [7:0] hdr;
    logic g;
    nb = (addr == 7'h03 || addr == 7'h0c || addr >= 7'h0f) ? 16 : 8;
    hdr = {rd, addr};
    rdata = 16'h0000;
    cs_n <= 1'b0;
    wait_clk(8);
    for (int i = 7; i >= 0; i--) bit_xfer(hdr[i], g);
    for (int i = 0; i < nb; i++) begin
      bit_xfer(wdata[nb-1-i], g);
      rdata = {rdata[14:0], g};
    end
    wait_clk(8);
    cs_n <= 1'b1;
    // released line must not keep showing the last bit
    sdi <= ~sdi;
    wait_clk(8);
  endtask

  // write frame dropped after n data bits; the device must not store it
  task automatic cut(input logic [6:0] addr, input logic [15:0] wdata, input int n);
    logic [7:0] hdr;
    logic g;
    hdr = {1'b0, addr};
    cs_n <= 1'b0;
    wait_clk(8);
    for (int i = 7; i >= 0; i--) bit_xfer(hdr[i], g);
    for (int i = 0; i < n; i++) bit_xfer(wdata[15-i], g);
    wait_clk(8);
    cs_n <= 1'b1;
    sdi <= ~sdi;
    wait_clk(8);
  endtask
endmodule // plh_host

`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [15:0] ID_VAL = 16'h3c3c; // arbitrary value
  logic core_clk, reset_n, cs_n, sclk, sdi, sdo, sdo_oe_n, result_valid, convert_strobe;
  logic [15:0] result_data, soft_reset_control, x;
  logic [7:0] convert_code, page_select, dac_output_enable, gpio_levels;
  logic [143:0] low_limits;
  logic [131:0] hysteresis;
  int miscompares, n_checks, n_strobe, n0, n_oe;

  plh_bank #(.DEV_ID(ID_VAL)) i_plh_bank (.core_clk(core_clk), .reset_n(reset_n),
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .result_valid(result_valid), .result_data(result_data),
    .convert_strobe(convert_strobe), .convert_code(convert_code),
    .page_select(page_select), .dac_output_enable(dac_output_enable),
    .gpio_levels(gpio_levels), .soft_reset_control(soft_reset_control),
    .low_limits(low_limits), .hysteresis(hysteresis));
  plh_host i_plh_host (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (convert_strobe === 1'b1) n_strobe++;
  always @(posedge core_clk) if (sdo_oe_n === 1'b0) n_oe++;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] y;
    i_plh_host.xfer(1'b0, a, d, y);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] y;
    i_plh_host.xfer(1'b1, a, 16'h0000, y);
    chk(y, e);
  endtask

  function automatic logic [15:0] low_at(input int i);
    return {low_limits[i*12+:12], 4'h0};
  endfunction

  function automatic logic [15:0] hyst_at(input int j);
    return {hysteresis[j*12+:12], 4'h0};
  endfunction

  function automatic logic [15:0] v(input int i);
    return {4'(i + 1), 8'ha5, 4'hf};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({15'h0, sdo_oe_n}, 16'h0001);
    chk({8'h0, page_select}, 16'h0000);
    rd_chk(7'h03, 16'h0000);
    rd_chk(7'h10, 16'h0000);
    $display("t_reset done");
  endtask

  task automatic t_low;
    wr(7'h01, 16'h0007);
    chk({8'h0, page_select}, 16'h0007);
    for (int i = 0; i < 12; i++) begin
      rd_chk(plh_pkg::LOW_OFS[i], 16'h0000);
      wr(plh_pkg::LOW_OFS[i], v(i));
      chk(low_at(i), v(i) & 16'hfff0);
      rd_chk(plh_pkg::LOW_OFS[i], v(i) & 16'hfff0);
    end
    for (int j = 0; j < 11; j++) chk(hyst_at(j), 16'h0000);
    rd_chk(7'h20, 16'h0000);
    $display("t_low done");
  endtask

  task automatic t_hyst;
    logic [15:0] w;
    wr(7'h01, 16'h0008);
    for (int j = 0; j < 11; j++) begin
      w = {4'h8 | 4'(j), 8'h3c, 4'ha};
      rd_chk(plh_pkg::HYST_OFS[j], 16'h0000);
      wr(plh_pkg::HYST_OFS[j], w);
      chk(hyst_at(j), w & 16'hfff0);
      rd_chk(plh_pkg::HYST_OFS[j], w & 16'hfff0);
    end
    rd_chk(7'h14, 16'h0000);
    chk(low_at(0), v(0) & 16'hfff0);
    $display("t_hyst done");
  endtask

  task automatic t_common;
    n0 = n_strobe;
    wr(7'h02, 16'h00c3);
    chk(16'(n_strobe - n0), 16'h0001);
    chk({8'h0, convert_code}, 16'h00c3);
    rd_chk(7'h02, 16'h0000);
    @(posedge core_clk);
    result_valid <= 1'b1;
    result_data <= 16'hbee7;
    @(posedge core_clk);
    result_valid <= 1'b0;
    rd_chk(7'h03, 16'hbee7);
    wr(7'h03, 16'h1111);
    rd_chk(7'h03, 16'hbee7);
    rd_chk(7'h0c, ID_VAL);
    n0 = n_oe;
    wr(7'h04, 16'h005a);
    wr(7'h05, 16'h00a5);
    wr(7'h0f, 16'h8001);
    chk(16'(n_oe - n0), 16'h0000);
    chk({dac_output_enable, gpio_levels}, 16'h5aa5);
    chk(soft_reset_control, 16'h8001);
    rd_chk(7'h04, 16'h005a);
    rd_chk(7'h05, 16'h00a5);
    rd_chk(7'h0f, 16'h8001);
    chk(16'(n_oe != n0), 16'h0001);
    wr(7'h01, 16'h0003);
    wr(7'h10, 16'hffff);
    rd_chk(7'h10, 16'h0000);
    chk(hyst_at(0), 16'h83c0);
    chk(low_at(0), 16'h1a50);
    rd_chk(7'h01, 16'h0003);
    $display("t_common done");
  endtask

  // reset in mid-run, then a write frame cut one bit short
  task automatic t_rerun;
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(16'(|low_limits), 16'h0000);
    chk(16'(|hysteresis), 16'h0000);
    chk({8'h0, page_select}, 16'h0000);
    rd_chk(7'h03, 16'h0000);
    wr(7'h01, 16'h0007);
    i_plh_host.cut(7'h10, 16'hffff, 15);
    chk(low_at(0), 16'h0000);
    rd_chk(7'h10, 16'h0000);
    $display("t_rerun done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    results();
  end

  initial begin
    reset_n = 1'b0;
    result_valid = 1'b0;
    result_data = 16'h0000;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_low();
    t_hyst();
    t_common();
    t_rerun();
    results();
  end
endmodule // testbench

`default_nettype wire
